//--- lpd_core.sv
// DRAM core command decoder, bank tracking and burst-read strobe/data path
// Functional notes
// [RQ1] Controller waits all-bank precharge time after precharge-all before activating.
// [RQ2] Same-bank activates spaced by row active plus applicable precharge time.
// [RQ3] After self-refresh exit wait max of refresh cycle plus 7.5 ns, 2 clocks.
// [RQ4] After power-down exit wait max of 7.5 ns and five clocks.
// [RQ5] Column commands 8 clocks apart for 16-beat bursts, 8 more for 32.
// [RQ6] Precharge after read to same bank waits max of 7.5 ns, 8 clocks.
// [RQ7] Activates to different banks spaced max 10 ns, 4 clocks; 7.5 ns fastest.
// [RQ8] Explicit precharges at least 4 clocks apart; auto-precharge exempt.
// [RQ9] Bank open time limited by refresh rate field and 70.2 microseconds.
// [RQ10] Reads taken only to open banks, from select and CA at rising edge.
// [RQ11] Each read starts an uninterruptible burst; length chosen per command.
// [RQ12] Two-clock read preamble, static or toggling as configured.
// [RQ13] Half-clock postamble, or 1.5 clocks when extended postamble is set.
// [RQ14] Two lowest column bits are zero; bursts start on multiples of four.
// [RQ15] Read latency counts from the rising edge completing the read command.
// [RQ16] Strobe driven one preamble before first rising edge carrying first bit.
// [RQ17] One data bit per strobe edge, edge aligned, on every data pin.
// [RQ18] No more than four activations within any rolling four-activate window.
// [RQ19] Controller rounds nanosecond minima up to clocks, takes larger count.
// [RQ20] Controller keeps per-bank timers for same-bank spacing; the model keeps one since counter shared by all banks.
`timescale 1ns/1ps
module lpd_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command link
  input wire logic ck_i,
  input wire logic cs_i,
  input wire logic [5:0] ca_i,
  // Read strobe and data pins
  output logic dqs_o,
  output logic dqs_oe_o,
  output logic [lpd_pkg::DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import lpd_pkg::*;

  typedef enum logic {CMD_IDLE, CMD_SECOND} lpd_cmd_e;

  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  logic ck_rise;
  logic ck_fall;
  logic cs_s;
  logic [5:0] ca_s;
  logic half;

  lpd_link_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ck_i(ck_i),
    .cs_i(cs_i),
    .ca_i(ca_i),
    .ck_rise_o(ck_rise),
    .ck_fall_o(ck_fall),
    .cs_o(cs_s),
    .ca_o(ca_s)
  );

  // Every link clock edge is one strobe half cycle
  assign half = ck_rise | ck_fall;

  logic [31:0] ctrl_ff;
  logic [2:0] rate_ff;
  logic [DQ_W-1:0] seed_ff;
  logic [RL_W-1:0] rl_fld;
  logic [RL_W-1:0] rl;
  assign rl_fld = ctrl_ff[CTRL_RL_LSB +: RL_W];
  // Below the minimum the preamble would start before the command completes
  assign rl = (rl_fld < RL_MIN) ? RL_MIN : rl_fld;

  // Command decoder and bank state
  lpd_cmd_e cmd_ff, nxt_cmd;
  logic [2:0] op_ff, nxt_op;
  logic [2:0] bank_ff, nxt_bank;
  logic [7:0] open_ff, nxt_open;
  logic rd_go;
  logic [5:0] rd_bl;
  logic ev_closed;

  always_comb begin
    nxt_cmd = cmd_ff;
    nxt_op = op_ff;
    nxt_bank = bank_ff;
    nxt_open = open_ff;
    rd_go = 1'b0;
    rd_bl = BL16;
    ev_closed = 1'b0;
    case (cmd_ff)
      CMD_IDLE: begin
        if (ck_rise && cs_s) begin // RQ10
          nxt_op = ca_s[5:3];
          nxt_bank = ca_s[2:0];
          nxt_cmd = CMD_SECOND;
        end
      end
      CMD_SECOND: begin
        if (ck_rise) begin
          nxt_cmd = CMD_IDLE;
          case (op_ff)
            OP_ACT: nxt_open[bank_ff] = 1'b1;
            OP_PRE: nxt_open[bank_ff] = 1'b0;
            OP_PREALL: nxt_open = 8'h00;
            OP_RD16, OP_RD32: begin
              rd_bl = (op_ff == OP_RD32) ? BL32 : BL16; // RQ11
              if (open_ff[bank_ff]) begin // RQ10
                rd_go = 1'b1;
              end else begin
                ev_closed = 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
      default: nxt_cmd = CMD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_ff <= CMD_IDLE;
      op_ff <= 3'h0;
      bank_ff <= 3'h0;
      open_ff <= 8'h00;
    end else begin
      cmd_ff <= nxt_cmd;
      op_ff <= nxt_op;
      bank_ff <= nxt_bank;
      open_ff <= nxt_open;
    end
  end

  // Burst engine: one active burst plus one waiting slot
  logic [HALF_W-1:0] tick_ff, nxt_tick;
  logic act_v_ff, nxt_act_v;
  logic pnd_v_ff, nxt_pnd_v;
  logic [HALF_W-1:0] act_st_ff, nxt_act_st;
  logic [HALF_W-1:0] pnd_st_ff, nxt_pnd_st;
  logic [5:0] act_bl_ff, nxt_act_bl;
  logic [5:0] pnd_bl_ff, nxt_pnd_bl;
  logic [5:0] act_col_ff, nxt_act_col;
  logic [5:0] pnd_col_ff, nxt_pnd_col;
  logic [1:0] pst_ff, nxt_pst;
  logic dqs_ff, nxt_dqs;
  logic dqs_oe_ff, nxt_dqs_oe;
  logic [DQ_W-1:0] dq_ff, nxt_dq;
  logic dq_oe_ff, nxt_dq_oe;
  logic ev_overrun;
  logic [HALF_W-1:0] rd_st;
  logic [HALF_W-1:0] pre_d;
  logic [HALF_W-1:0] beat;
  logic [HALF_W-1:0] act_len;

  always_comb begin
    nxt_tick = tick_ff;
    nxt_act_v = act_v_ff;
    nxt_pnd_v = pnd_v_ff;
    nxt_act_st = act_st_ff;
    nxt_pnd_st = pnd_st_ff;
    nxt_act_bl = act_bl_ff;
    nxt_pnd_bl = pnd_bl_ff;
    nxt_act_col = act_col_ff;
    nxt_pnd_col = pnd_col_ff;
    nxt_pst = pst_ff;
    nxt_dqs = dqs_ff;
    nxt_dqs_oe = dqs_oe_ff;
    nxt_dq = dq_ff;
    nxt_dq_oe = dq_oe_ff;
    ev_overrun = 1'b0;
    rd_st = tick_ff + {9'h000, rl, 1'b0}; // RQ15
    pre_d = act_st_ff - tick_ff;
    beat = tick_ff - act_st_ff;
    act_len = {10'h000, act_bl_ff};
    if (half) begin
      nxt_tick = tick_ff + 16'h0001;
      nxt_dqs = 1'b0;
      nxt_dqs_oe = 1'b0;
      nxt_dq_oe = 1'b0;
      if (pst_ff != 2'h0) begin // RQ13
        nxt_dqs_oe = 1'b1;
        nxt_dqs = (pst_ff == PST_EXT_HALVES);
        nxt_pst = pst_ff - 2'h1;
      end
      if (act_v_ff && pre_d >= 16'h0001 && pre_d <= PRE_HALVES) begin // RQ12 RQ16
        nxt_dqs_oe = 1'b1;
        nxt_dqs = ctrl_ff[CTRL_PRE_TOG_BIT] & ~pre_d[0];
      end else if (act_v_ff && beat < act_len) begin
        nxt_dqs_oe = 1'b1;
        nxt_dq_oe = 1'b1;
        nxt_dqs = ~beat[0]; // RQ16 RQ17
        nxt_dq = seed_ff ^ ({act_col_ff, 2'b00} + beat[7:0]); // RQ14 RQ17
        if (beat == act_len - 16'h0001) begin
          nxt_act_v = pnd_v_ff;
          nxt_act_st = pnd_st_ff;
          nxt_act_bl = pnd_bl_ff;
          nxt_act_col = pnd_col_ff;
          nxt_pnd_v = 1'b0;
          // Seamless follow-on at column spacing skips the postamble
          if (!(pnd_v_ff && pnd_st_ff == act_st_ff + act_len)) begin // RQ5
            nxt_pst = ctrl_ff[CTRL_PST_EXT_BIT] ? PST_EXT_HALVES : PST_STD_HALVES; // RQ13
          end
        end
      end
    end
    if (rd_go) begin
      if (!nxt_act_v) begin
        nxt_act_v = 1'b1;
        nxt_act_st = rd_st;
        nxt_act_bl = rd_bl;
        nxt_act_col = ca_s; // RQ14
      end else if (!nxt_pnd_v) begin // RQ11
        nxt_pnd_v = 1'b1;
        nxt_pnd_st = rd_st;
        nxt_pnd_bl = rd_bl;
        nxt_pnd_col = ca_s;
      end else begin
        ev_overrun = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_ff <= 16'h0000;
      act_v_ff <= 1'b0;
      pnd_v_ff <= 1'b0;
      act_st_ff <= 16'h0000;
      pnd_st_ff <= 16'h0000;
      act_bl_ff <= BL16;
      pnd_bl_ff <= BL16;
      act_col_ff <= 6'h00;
      pnd_col_ff <= 6'h00;
      pst_ff <= 2'h0;
      dqs_ff <= 1'b0;
      dqs_oe_ff <= 1'b0;
      dq_ff <= 8'h00;
      dq_oe_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
      act_v_ff <= nxt_act_v;
      pnd_v_ff <= nxt_pnd_v;
      act_st_ff <= nxt_act_st;
      pnd_st_ff <= nxt_pnd_st;
      act_bl_ff <= nxt_act_bl;
      pnd_bl_ff <= nxt_pnd_bl;
      act_col_ff <= nxt_act_col;
      pnd_col_ff <= nxt_pnd_col;
      pst_ff <= nxt_pst;
      dqs_ff <= nxt_dqs;
      dqs_oe_ff <= nxt_dqs_oe;
      dq_ff <= nxt_dq;
      dq_oe_ff <= nxt_dq_oe;
    end
  end

  assign dqs_o = dqs_ff;
  assign dqs_oe_o = dqs_oe_ff;
  assign dq_o = dq_ff;
  assign dq_oe_o = dq_oe_ff;

  // Wishbone register file
  logic [31:0] nxt_ctrl;
  logic [2:0] nxt_rate;
  logic [DQ_W-1:0] nxt_seed;
  logic [1:0] ev_ff, nxt_ev;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic req;
  logic wr;
  logic [1:0] ev_clr;
  logic [31:0] merged;
  logic busy;

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  // Writes commit on the edge where the master sees ack
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign busy = act_v_ff | pnd_v_ff | (pst_ff != 2'h0);

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rate = rate_ff;
    nxt_seed = seed_ff;
    nxt_ack = req;
    nxt_rdat = 32'h0000_0000;
    ev_clr = 2'h0;
    merged = 32'h0000_0000;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: nxt_rdat = ctrl_ff;
        REG_REFRESH_STATUS: nxt_rdat = {29'h0000_0000, rate_ff};
        REG_STATUS: nxt_rdat = {23'h00_0000, busy, open_ff};
        REG_EVENTS: nxt_rdat = {30'h0000_0000, ev_ff};
        REG_SEED: nxt_rdat = {24'h00_0000, seed_ff};
        default: nxt_rdat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        REG_CTRL: nxt_ctrl = wmerge(ctrl_ff, wb_dat_i, wb_sel_i) & CTRL_MASK;
        REG_REFRESH_STATUS: begin
          merged = wmerge({29'h0000_0000, rate_ff}, wb_dat_i, wb_sel_i);
          nxt_rate = merged[2:0]; // RQ9
        end
        REG_EVENTS: ev_clr = wb_sel_i[0] ? wb_dat_i[1:0] : 2'h0;
        REG_SEED: begin
          merged = wmerge({24'h00_0000, seed_ff}, wb_dat_i, wb_sel_i);
          nxt_seed = merged[7:0];
        end
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle
    nxt_ev = (ev_ff & ~ev_clr);
    nxt_ev[EV_CLOSED_BIT] = nxt_ev[EV_CLOSED_BIT] | ev_closed;
    nxt_ev[EV_OVERRUN_BIT] = nxt_ev[EV_OVERRUN_BIT] | ev_overrun;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
      rate_ff <= RATE_RST;
      seed_ff <= SEED_RST;
      ev_ff <= 2'h0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rate_ff <= nxt_rate;
      seed_ff <= nxt_seed;
      ev_ff <= nxt_ev;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
endmodule

//--- lpd_core_asserts.sv
// Checker of strobe, data and bus timing at the core's ports
`timescale 1ns/1ps
module lpd_core_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Read pins
  input wire logic dqs_o,
  input wire logic dqs_oe_o,
  input wire logic [lpd_pkg::DQ_W-1:0] dq_o,
  input wire logic dq_oe_o,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  import lpd_pkg::*;
  logic [9:0] run_ff;
  logic [9:0] nxt_run;

  // Length of the current data run; a beat is four clocks at this link rate
  always_comb begin
    nxt_run = dq_oe_o ? run_ff + 10'h001 : 10'h000;
  end
  always_ff @(posedge clk_i) begin
    run_ff <= rst_i ? 10'h000 : nxt_run;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pre;
    (dqs_oe_o && !dq_oe_o) [*8];
  endsequence
  sequence s_post;
    dqs_oe_o [*3] ##[1:10] $fell(dqs_oe_o);
  endsequence

  pre_len_a: assert property ($rose(dqs_oe_o) |-> s_pre ##[6:10] $rose(dq_oe_o))
    else $error("preamble length wrong");
  pre_lead_a: assert property ($rose(dq_oe_o) |-> dqs_o && $past(dqs_oe_o, 12))
    else $error("first beat not after preamble");
  data_strobe_a: assert property (dq_oe_o |-> dqs_oe_o)
    else $error("data without strobe");
  beat_edge_a: assert property (dq_oe_o && $past(dq_oe_o) |-> $changed(dq_o) == $changed(dqs_o))
    else $error("data not aligned to strobe edge");
  burst_len_a: assert property ($fell(dq_oe_o) |-> run_ff[5:0] == 6'h00 && run_ff != 10'h000)
    else $error("burst cut short");
  post_len_a: assert property ($fell(dq_oe_o) |-> s_post)
    else $error("postamble length wrong");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  idle_dat_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("bus data outside ack");
endmodule

bind lpd_core lpd_core_asserts lpd_core_asserts_i (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .dqs_o(dqs_o),
  .dqs_oe_o(dqs_oe_o),
  .dq_o(dq_o),
  .dq_oe_o(dq_oe_o),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o)
);

//--- lpd_ctrl_model.sv
// Behavioural memory controller driving the command link
`timescale 1ns/1ps
module lpd_ctrl_model (
  // Link pins
  output logic ck_o,
  output logic cs_o,
  output logic [5:0] ca_o
);
  int since;
  realtime t_cas;

  // Runs free: read beats are timed off this clock
  initial begin
    ck_o = 1'b0;
    cs_o = 1'b0;
    ca_o = 6'h00;
    since = 99;
    #7;
    forever #100 ck_o = ~ck_o;
  end
  always @(posedge ck_o) since <= since + 1;

  task automatic cmd(input logic [2:0] op, input logic [2:0] bank, input logic [5:0] arg,
                     input int gap);
    // Whole clocks cover every ns minimum at this slow rate
    if (gap < 4) gap = 4;
    do @(negedge ck_o); while (since < gap);
    cs_o = 1'b1;
    ca_o = {op, bank};
    since = 0;
    @(negedge ck_o);
    cs_o = 1'b0;
    ca_o = arg;
    @(negedge ck_o);
    ca_o = ~arg;
    // Latency counts from the second command edge, half a clock back
    t_cas = $realtime - 100;
  endtask
endmodule

//--- lpd_link_sync.sv
// Synchroniser and edge finder for the command clock, select and CA lines
`timescale 1ns/1ps
module lpd_link_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link pins
  input wire logic ck_i,
  input wire logic cs_i,
  input wire logic [5:0] ca_i,
  // Synchronised view
  output logic ck_rise_o,
  output logic ck_fall_o,
  output logic cs_o,
  output logic [5:0] ca_o
);
  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic ck_prev_ff;
  logic [7:0] nxt_s1;
  logic [7:0] nxt_s2;
  logic nxt_ck_prev;

  always_comb begin
    nxt_s1 = {ck_i, cs_i, ca_i};
    nxt_s2 = s1_ff;
    nxt_ck_prev = s2_ff[7];
  end

  // Select and CA share the clock's delay, so they are seen at its edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      ck_prev_ff <= 1'b0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      ck_prev_ff <= nxt_ck_prev;
    end
  end

  assign ck_rise_o = s2_ff[7] & ~ck_prev_ff;
  assign ck_fall_o = ~s2_ff[7] & ck_prev_ff;
  assign cs_o = s2_ff[6];
  assign ca_o = s2_ff[5:0];
endmodule

//--- lpd_pkg.sv
// Constants for the DRAM core command decoder and burst-read data path
package lpd_pkg;
  localparam int unsigned DQ_W = 8;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned RL_W = 6;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_REFRESH_STATUS = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_EVENTS = 8'h0C;
  localparam logic [7:0] REG_SEED = 8'h10;

  // Control register fields and reset values
  localparam int unsigned CTRL_RL_LSB = 0;
  localparam int unsigned CTRL_PRE_TOG_BIT = 8;
  localparam int unsigned CTRL_PST_EXT_BIT = 9;
  localparam logic [31:0] CTRL_MASK = 32'h0000_033F;
  localparam logic [31:0] CTRL_RST = 32'h0000_000E;
  localparam logic [RL_W-1:0] RL_MIN = 6'h03;
  localparam logic [2:0] RATE_RST = 3'h3;
  localparam logic [DQ_W-1:0] SEED_RST = 8'h00;
  localparam int unsigned STATUS_BUSY_BIT = 8;
  localparam int unsigned EV_CLOSED_BIT = 0;
  localparam int unsigned EV_OVERRUN_BIT = 1;

  // Command opcodes on CA[5:3] of the first edge
  localparam logic [2:0] OP_ACT = 3'h1;
  localparam logic [2:0] OP_PRE = 3'h2;
  localparam logic [2:0] OP_PREALL = 3'h3;
  localparam logic [2:0] OP_RD16 = 3'h4;
  localparam logic [2:0] OP_RD32 = 3'h5;

  // Burst, preamble and postamble lengths in strobe half cycles
  localparam logic [5:0] BL16 = 6'h10;
  localparam logic [5:0] BL32 = 6'h20;
  localparam logic [HALF_W-1:0] PRE_HALVES = 16'h0004;
  localparam logic [1:0] PST_STD_HALVES = 2'h1;
  localparam logic [1:0] PST_EXT_HALVES = 2'h3;
endpackage

//--- test_lpd_core.sv
// Self-checking bench for the core's read path and registers
`timescale 1ns/1ps
module test_lpd_core;
  import lpd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o;
  wire logic dqs_o;
  wire logic dqs_oe_o;
  wire logic [DQ_W-1:0] dq_o;
  wire logic dq_oe_o;
  wire logic ck;
  wire logic cs;
  wire logic [5:0] ca;
  int checks = 0;
  int error_cnt = 0;
  int cyc_cnt = 0;
  int k;
  int rl;
  logic tog;
  logic ext;
  logic seen_oe;
  logic [7:0] sd;
  logic [31:0] rd_q;
  logic [31:0] rv [0:5] = '{32'h0000_000E, 32'h0000_0003, 32'h0, 32'h0, 32'h0, 32'h0};

  always #12.5 clk_i = ~clk_i;

  lpd_ctrl_model lpd_ctrl_model_i (.ck_o(ck), .cs_o(cs), .ca_o(ca));
  lpd_core lpd_core_i (.clk_i(clk_i), .rst_i(rst_i), .ck_i(ck), .cs_i(cs), .ca_i(ca),
    .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  task automatic conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd_q, e);
  endtask

  // Samples each strobe half in its middle, pre- and postamble included
  task automatic run_rd(input int bl, input int nb, input int f0, input int f1);
    int n;
    int b;
    logic [63:0] sv;
    logic [63:0] ov;
    logic [7:0] q [0:63];
    real lat;
    while (dqs_oe_o !== 1'b1) @(posedge clk_i);
    lat = ($realtime - lpd_ctrl_model_i.t_cas) / 25.0;
    if (nb == 1) chk(lat >= 8 * rl - 14 && lat <= 8 * rl - 10, 1);
    repeat (2) @(posedge clk_i);
    n = 0;
    while (dqs_oe_o === 1'b1 && n < 64) begin
      sv[n] = dqs_o;
      ov[n] = dq_oe_o;
      q[n] = dq_o;
      n++;
      repeat (4) @(posedge clk_i);
    end
    chk(n, 4 + bl * nb + (ext ? 3 : 1));
    for (k = 0; k < n; k++) begin
      b = k - 4;
      if (k < 4) chk({ov[k], sv[k]}, {1'b0, tog & ~k[0]});
      else if (b < bl * nb) chk({ov[k], sv[k], q[k]},
        {1'b1, ~b[0], sd ^ 8'((b < bl ? f0 : f1) * 4 + b % bl)});
      else chk({ov[k], sv[k]}, {1'b0, ext && b == bl * nb});
    end
  endtask

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      conclude;
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rc(8'(4 * i), rv[i]);
    wb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    wb(1'b1, 8'h14, 32'hFFFF_FFFF);
    rc(REG_STATUS, 32'h0000_0000);
    rc(8'h14, 32'h0000_0000);
    wb(1'b1, REG_CTRL, 32'hFFFF_FFFF);
    rc(REG_CTRL, CTRL_MASK);
    sd = 8'h5A;
    wb(1'b1, REG_SEED, 32'h0000_005A);
    wb(1'b1, REG_REFRESH_STATUS, 32'hFFFF_FFFD);
    rc(REG_REFRESH_STATUS, 32'h0000_0005);
    // Static preamble, short postamble, latency 14
    wb(1'b1, REG_CTRL, 32'h0000_000E);
    rl = 14;
    tog = 1'b0;
    ext = 1'b0;
    lpd_ctrl_model_i.cmd(OP_ACT, 3'h0, 6'h00, 4);
    lpd_ctrl_model_i.cmd(OP_RD16, 3'h0, 6'h01, 4);
    run_rd(16, 1, 1, 0);
    rc(REG_STATUS, 32'h0000_0001);
    // Toggling preamble, long postamble, latency 10, long burst
    wb(1'b1, REG_CTRL, 32'h0000_030A);
    rl = 10;
    tog = 1'b1;
    ext = 1'b1;
    lpd_ctrl_model_i.cmd(OP_RD32, 3'h0, 6'h03, 8);
    rc(REG_STATUS, 32'h0000_0101);
    run_rd(32, 1, 3, 0);
    // Back-to-back reads at the minimum column spacing
    lpd_ctrl_model_i.cmd(OP_RD16, 3'h0, 6'h00, 8);
    lpd_ctrl_model_i.cmd(OP_RD16, 3'h0, 6'h02, 8);
    run_rd(16, 2, 0, 2);
    // Reads to closed banks are refused
    lpd_ctrl_model_i.cmd(OP_PRE, 3'h0, 6'h00, 8);
    lpd_ctrl_model_i.cmd(OP_RD16, 3'h0, 6'h01, 4);
    lpd_ctrl_model_i.cmd(OP_RD16, 3'h5, 6'h01, 8);
    seen_oe = 1'b0;
    repeat (320) begin
      @(posedge clk_i);
      if (dqs_oe_o !== 1'b0) seen_oe = 1'b1;
    end
    chk(seen_oe, 1'b0);
    rc(REG_EVENTS, 32'h0000_0001);
    wb(1'b1, REG_EVENTS, 32'h0000_0001);
    rc(REG_EVENTS, 32'h0000_0000);
    lpd_ctrl_model_i.cmd(OP_ACT, 3'h2, 6'h00, 4);
    // Third read while two bursts are held is dropped and flagged
    lpd_ctrl_model_i.cmd(OP_RD16, 3'h2, 6'h00, 4);
    lpd_ctrl_model_i.cmd(OP_RD16, 3'h2, 6'h01, 8);
    lpd_ctrl_model_i.cmd(OP_RD16, 3'h2, 6'h02, 8);
    rc(REG_EVENTS, 32'h0000_0002);
    // Long gap lets the held bursts drain before status is read
    lpd_ctrl_model_i.cmd(OP_PREALL, 3'h0, 6'h00, 16);
    rc(REG_STATUS, 32'h0000_0000);
    conclude;
  end
endmodule
